// [src/acsr_consts.svh]
// offsets, field positions, reset values and timing counts of the angle clock and sync line router
`ifndef ACSR_CONSTS_SVH
`define ACSR_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ACSR_ADDR_ANGLE_SEL0 12'h000
`define ACSR_ADDR_ANGLE_SEL1 12'h004
`define ACSR_ADDR_SYNC_SEL0 12'h008
`define ACSR_ADDR_SYNC_SEL1 12'h00C
`define ACSR_ADDR_LEVEL 12'h010
`define ACSR_ADDR_STATUS 12'h014
`define ACSR_ADDR_SYNC_STEP 12'h004

// ----------------------------------------
// select codes
// ----------------------------------------
`define ACSR_SEL_NONE 8'h00
`define ACSR_SEL_BP0 8'h01
`define ACSR_SEL_BP1 8'h02
`define ACSR_SEL_SW 8'h03
`define ACSR_SEL_SLOT0 8'h04
`define ACSR_SEL_SLOT5 8'h09

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define ACSR_SEL_W 8
`define ACSR_SYNC_PER_REG 4
`define ACSR_SEL_RESET 8'h00
`define ACSR_LEVEL_RESET 6'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define ACSR_CLK_PERIOD_NS 10
`define ACSR_REFRESH_MIN_MS 1
`define ACSR_REFRESH_MIN_CYC ((`ACSR_REFRESH_MIN_MS * 1000000) / `ACSR_CLK_PERIOD_NS)

`endif

// [src/acsr_pkg.sv]
// types of the angle clock and sync line router
package acsr_pkg;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	// one crank angle clock bus: three lines moving as a unit
	typedef struct packed {
		logic zero_mark;
		logic angle_clock;
		logic direction;
	} acsr_angle_s;

	typedef logic [7:0] acsr_sel_t;

	typedef struct packed {
		acsr_angle_s val;
		logic oe;
	} acsr_angle_drv_s;

	typedef enum logic [1:0] {
		ACSR_BUS_IDLE = 2'b00,
		ACSR_BUS_DATA = 2'b01
	} acsr_bus_e;

endpackage : acsr_pkg

// [src/acsr_angle_mux.sv]
// source selector for one internal crank angle clock bus
`timescale 1ns/100ps
`include "acsr_consts.svh"

module acsr_angle_mux (
	// select
	input wire acsr_pkg::acsr_sel_t sel,
	// sources
	input wire acsr_pkg::acsr_angle_s bp0,
	input wire acsr_pkg::acsr_angle_s bp1,
	input wire acsr_pkg::acsr_angle_s [5:0] slot,
	// result
	output acsr_pkg::acsr_angle_drv_s drv
);
	import acsr_pkg::*;

	always_comb begin
		drv = '0;
		// one source at most; none and reserved codes leave the bus undriven
		if (sel == `ACSR_SEL_BP0) begin
			drv.val = bp0;
			drv.oe = 1'b1;
		end else if (sel == `ACSR_SEL_BP1) begin
			drv.val = bp1;
			drv.oe = 1'b1;
		end else if (sel >= `ACSR_SEL_SLOT0 && sel <= `ACSR_SEL_SLOT5) begin
			drv.val = slot[3'(sel - `ACSR_SEL_SLOT0)];
			drv.oe = 1'b1;
		end
	end

endmodule : acsr_angle_mux

// [src/acsr_sync_mux.sv]
// source selector for one synchronization line
`timescale 1ns/100ps
`include "acsr_consts.svh"

module acsr_sync_mux (
	// select and level
	input wire acsr_pkg::acsr_sel_t sel,
	input wire logic level,
	// sources
	input wire logic bp0,
	input wire logic bp1,
	input wire logic [5:0] slot,
	// result
	output logic val,
	output logic oe
);
	import acsr_pkg::*;

	always_comb begin
		val = 1'b0;
		oe = 1'b0;
		if (sel == `ACSR_SEL_BP0) begin
			val = bp0;
			oe = 1'b1;
		end else if (sel == `ACSR_SEL_BP1) begin
			val = bp1;
			oe = 1'b1;
		end else if (sel == `ACSR_SEL_SW) begin
			// level bit only matters here
			val = level;
			oe = 1'b1;
		end else if (sel >= `ACSR_SEL_SLOT0 && sel <= `ACSR_SEL_SLOT5) begin
			val = slot[3'(sel - `ACSR_SEL_SLOT0)];
			oe = 1'b1;
		end
	end

endmodule : acsr_sync_mux

// [src/acsr_router.sv]
// angle clock and sync line router with AHB-Lite register slave
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "acsr_consts.svh"

// Function
// - each crank angle clock bus is three lines handled as one unit
// - lines are zero mark, angle clock pulses and running direction
// - at most one source drives an angle bus at a time
// - two internal angle buses, each with its own select
// - angle select: 0 none, 1-2 backplane buses, 3 reserved, 4-9 slots
// - none selection leaves the angle bus undriven
// - selects may change at any time while running
// - each sync line routed on its own select
// - sync bus goes to central logic and all six slots
// - each sync line has at most one driving source
// - any sync line may take either backplane sync line
// - software-controlled line follows its level bit, 0 low, 1 high
// - level bit ignored unless its line is under software control
// - sync select: 0 none, 1-2 backplane lines, 3 software, 4-9 slots
module acsr_router (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// backplane angle buses and sync lines
	input wire acsr_pkg::acsr_angle_s bp_angle0,
	input wire acsr_pkg::acsr_angle_s bp_angle1,
	input wire logic bp_sync0,
	input wire logic bp_sync1,
	// module slot sources
	input wire acsr_pkg::acsr_angle_s [5:0] slot_angle,
	input wire logic [5:0] slot_sync,
	// internal angle buses
	output acsr_pkg::acsr_angle_s [1:0] angle_bus,
	output logic [1:0] angle_bus_oe,
	// internal sync bus, to central logic and every slot
	output logic [5:0] sync_bus,
	output logic [5:0] sync_bus_oe
);
	import acsr_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		acsr_bus_e phase;
		logic [11:0] addr;
		logic wr;
		acsr_sel_t [1:0] angle_sel;
		acsr_sel_t [5:0] sync_sel;
		logic [5:0] level;
		logic [31:0] rdata;
		acsr_angle_s [1:0] bpa_s1;
		acsr_angle_s [1:0] bpa_s2;
		acsr_angle_s [1:0] bpa_s3;
		logic [1:0] bps_s1;
		logic [1:0] bps_s2;
		logic [1:0] bps_s3;
		logic [1:0] bps_f;
		acsr_angle_s [1:0] bpa_f;
		acsr_angle_s [1:0] ang_out;
		logic [1:0] ang_oe;
		logic [5:0] sync_out;
		logic [5:0] sync_oe;
	} acsr_state_s;

	acsr_state_s state_q;
	acsr_state_s state_d;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a <= `ACSR_ADDR_STATUS) && (a[1:0] == 2'b00);
	endfunction : is_mapped

	function automatic int sync_index(input logic [11:0] a, input int k);
		sync_index = (a == `ACSR_ADDR_SYNC_SEL1) ? k + `ACSR_SYNC_PER_REG : k;
	endfunction : sync_index

	// ----------------------------------------
	// routing
	// ----------------------------------------
	acsr_angle_drv_s [1:0] angle_drv;
	logic [5:0] sync_val;
	logic [5:0] sync_oe_c;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_angle
			// independent select per internal bus
			acsr_angle_mux u_angle (
				.sel(state_q.angle_sel[gi]),
				.bp0(state_q.bpa_f[0]),
				.bp1(state_q.bpa_f[1]),
				.slot(slot_angle),
				.drv(angle_drv[gi])
			);
		end
		for (gi = 0; gi < 6; gi++) begin : g_sync
			acsr_sync_mux u_sync (
				.sel(state_q.sync_sel[gi]),
				.level(state_q.level[gi]),
				.bp0(state_q.bps_f[0]),
				.bp1(state_q.bps_f[1]),
				.slot(slot_sync),
				.val(sync_val[gi]),
				.oe(sync_oe_c[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic take;
	logic [31:0] rd;

	always_comb begin
		state_d = state_q;
		take = hsel && hready && htrans[1];
		rd = 32'h0000_0000;

		// backplane pins: three stages, change accepted when last two agree
		state_d.bpa_s1 = {bp_angle1, bp_angle0};
		state_d.bpa_s2 = state_q.bpa_s1;
		state_d.bpa_s3 = state_q.bpa_s2;
		state_d.bps_s1 = {bp_sync1, bp_sync0};
		state_d.bps_s2 = state_q.bps_s1;
		state_d.bps_s3 = state_q.bps_s2;
		// whole three-line group moves at once so lines stay aligned
		for (int b = 0; b < 2; b++) begin
			if (state_q.bpa_s2[b] == state_q.bpa_s3[b]) begin
				state_d.bpa_f[b] = state_q.bpa_s3[b];
			end
			if (state_q.bps_s2[b] == state_q.bps_s3[b]) begin
				state_d.bps_f[b] = state_q.bps_s3[b];
			end
		end

		// data phase of an earlier write; takes effect at once, no stop needed
		if (state_q.phase == ACSR_BUS_DATA && state_q.wr) begin
			if (state_q.addr == `ACSR_ADDR_ANGLE_SEL0) begin
				state_d.angle_sel[0] = hwdata[7:0];
			end else if (state_q.addr == `ACSR_ADDR_ANGLE_SEL1) begin
				state_d.angle_sel[1] = hwdata[7:0];
			end else if (state_q.addr == `ACSR_ADDR_SYNC_SEL0 || state_q.addr == `ACSR_ADDR_SYNC_SEL1) begin
				for (int k = 0; k < `ACSR_SYNC_PER_REG; k++) begin
					if (sync_index(state_q.addr, k) < 6) begin
						state_d.sync_sel[sync_index(state_q.addr, k)] = hwdata[8*k +: 8];
					end
				end
			end else if (state_q.addr == `ACSR_ADDR_LEVEL) begin
				// host paces these writes; no minimum spacing is enforced here
				state_d.level = hwdata[5:0];
			end
		end

		// address phase
		if (take) begin
			state_d.phase = ACSR_BUS_DATA;
			state_d.addr = haddr;
			state_d.wr = hwrite;
			if (!hwrite && is_mapped(haddr)) begin
				if (haddr == `ACSR_ADDR_ANGLE_SEL0) begin
					rd = {24'h000000, state_q.angle_sel[0]};
				end else if (haddr == `ACSR_ADDR_ANGLE_SEL1) begin
					rd = {24'h000000, state_q.angle_sel[1]};
				end else if (haddr == `ACSR_ADDR_SYNC_SEL0) begin
					rd = {state_q.sync_sel[3], state_q.sync_sel[2], state_q.sync_sel[1], state_q.sync_sel[0]};
				end else if (haddr == `ACSR_ADDR_SYNC_SEL1) begin
					rd = {16'h0000, state_q.sync_sel[5], state_q.sync_sel[4]};
				end else if (haddr == `ACSR_ADDR_LEVEL) begin
					rd = {26'h0, state_q.level};
				end else begin
					// live view of what the router is driving
					rd = {18'h00000, state_q.sync_out, state_q.sync_oe, state_q.ang_oe};
				end
			end
			state_d.rdata = rd;
		end else if (hready) begin
			state_d.phase = ACSR_BUS_IDLE;
			state_d.wr = 1'b0;
		end

		// registered outputs
		for (int b = 0; b < 2; b++) begin
			state_d.ang_out[b] = angle_drv[b].val;
			state_d.ang_oe[b] = angle_drv[b].oe;
		end
		state_d.sync_out = sync_val;
		state_d.sync_oe = sync_oe_c;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hrdata = state_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign angle_bus = state_q.ang_out;
	assign angle_bus_oe = state_q.ang_oe;
	// same wires feed central logic and each slot
	assign sync_bus = state_q.sync_out;
	assign sync_bus_oe = state_q.sync_oe;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	angle_none_float_a: assert property (state_q.angle_sel[0] == `ACSR_SEL_NONE |=> !angle_bus_oe[0])
		else $error("angle bus 0 driven with none select");
	angle_reserved_a: assert property (state_q.angle_sel[1] == 8'h03 |=> !angle_bus_oe[1])
		else $error("reserved angle select drove bus 1");
	angle_bp0_follow_a: assert property (state_q.angle_sel[0] == `ACSR_SEL_BP0 |=> angle_bus_oe[0]
		&& angle_bus[0] == $past(state_q.bpa_f[0]))
		else $error("angle bus 0 not following backplane bus 0");
	angle_bus1_own_a: assert property ($changed(state_q.angle_sel[0]) && $stable(state_q.angle_sel[1])
		&& state_q.angle_sel[1] == `ACSR_SEL_NONE |=> !angle_bus_oe[1])
		else $error("angle bus 1 reacted to select of bus 0");
	sync_sw_level_a: assert property (state_q.sync_sel[2] == `ACSR_SEL_SW |=> sync_bus_oe[2]
		&& sync_bus[2] == $past(state_q.level[2]))
		else $error("software sync line does not follow its level");
	sync_level_ignored_a: assert property (state_q.sync_sel[0] == `ACSR_SEL_BP1 |=> sync_bus[0]
		== $past(state_q.bps_f[1]))
		else $error("sync line 0 not following backplane line 1");
	sync_slot_route_a: assert property (state_q.sync_sel[5] == 8'h09 |=> sync_bus_oe[5]
		&& sync_bus[5] == $past(slot_sync[5]))
		else $error("sync line 5 not following slot 5");
	sel_write_live_a: assert property (take && hwrite && haddr == `ACSR_ADDR_ANGLE_SEL0 ##1 hready
		|=> state_q.angle_sel[0] == $past(hwdata[7:0]))
		else $error("angle select write not taken");
	sync_indep_a: assert property (state_q.sync_sel[1] == `ACSR_SEL_NONE [*2] |-> !sync_bus_oe[1])
		else $error("idle sync line 1 driven");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("register bus stalled or answered with an error");

	sw_level_c: cover property (state_q.sync_sel[3] == `ACSR_SEL_SW ##1 $changed(sync_bus[3]));
	angle_slot_c: cover property (state_q.angle_sel[1] == 8'h04 ##1 angle_bus_oe[1]);
	bp_sync_c: cover property (state_q.sync_sel[4] == `ACSR_SEL_BP0 ##1 sync_bus_oe[4]);

endmodule : acsr_router

// [tb/acsr_far_side.sv]
// backplane buses and module slots that feed the router
`timescale 1ns/100ps
module acsr_far_side (
	// bench control
	input wire logic flip,
	input wire logic run,
	// backplane sources
	output acsr_pkg::acsr_angle_s bp_angle0,
	output acsr_pkg::acsr_angle_s bp_angle1,
	output logic bp_sync0,
	output logic bp_sync1,
	// slot sources
	output acsr_pkg::acsr_angle_s [5:0] slot_angle,
	output logic [5:0] slot_sync
);
	import acsr_pkg::*;
	// ----------------------------------------
	// sources
	// ----------------------------------------
	// pulses only while the engine turns, still otherwise
	logic pulse_q = 1'b0;
	always #40 pulse_q = run ? ~pulse_q : 1'b0;
	// zero mark, angle pulses, direction as one group
	assign bp_angle0 = {flip, pulse_q ^ flip, flip};
	assign bp_angle1 = {3{flip}} ^ 3'h1;
	assign bp_sync0 = flip;
	assign bp_sync1 = ~flip;
	// a slot keeps driving its line whatever it watches on others
	assign slot_sync = {6{flip}} ^ 6'h1A;
	for (genvar k = 0; k < 6; k++) begin : g_slot
		assign slot_angle[k] = {3{flip}} ^ 3'(k + 2);
	end
endmodule : acsr_far_side

// [tb/angle_clock_and_sync_line_router_test.sv]
// self-checking bench for the angle clock and sync line router
`timescale 1ns/100ps
`include "acsr_consts.svh"
module angle_clock_and_sync_line_router_test;
	import acsr_pkg::*;
	// select code, angle oe, sync oe
	typedef struct packed {acsr_sel_t code; logic aoe; logic soe;} acsr_row_s;
	acsr_row_s rows [12] = '{10'h000, 10'h007, 10'h00B, 10'h00D, 10'h013, 10'h017,
		10'h01B, 10'h01F, 10'h023, 10'h027, 10'h028, 10'h3FC};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic flip = 1'b0;
	logic run = 1'b0;
	logic [5:0] lvl = 6'h29;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	acsr_angle_s bp_angle0, bp_angle1;
	logic bp_sync0, bp_sync1;
	acsr_angle_s [5:0] slot_angle;
	logic [5:0] slot_sync;
	acsr_angle_s [1:0] angle_bus;
	logic [1:0] angle_bus_oe;
	logic [5:0] sync_bus, sync_bus_oe;
	int num_errors = 0;
	int total_checks = 0;
	int n;
	logic p;

	always #5 hclk = ~hclk;

	// hready follows the single slave's own hreadyout
	acsr_router acsr_router_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .bp_angle0, .bp_angle1, .bp_sync0, .bp_sync1,
		.slot_angle, .slot_sync, .angle_bus, .angle_bus_oe, .sync_bus, .sync_bus_oe);
	acsr_far_side acsr_far_side_i (.flip, .run, .bp_angle0, .bp_angle1, .bp_sync0, .bp_sync1,
		.slot_angle, .slot_sync);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : ahb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] unused;
		ahb(1'b1, a, d, unused);
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(d, exp);
	endtask : rdchk

	function automatic logic [2:0] angle_exp(input acsr_sel_t c);
		case (c)
			8'h01: return bp_angle0;
			8'h02: return bp_angle1;
			8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09: return slot_angle[c - 8'h04];
			default: return 3'h0;
		endcase
	endfunction : angle_exp

	function automatic logic sync_exp(input acsr_sel_t c, input int k);
		case (c)
			8'h01: return bp_sync0;
			8'h02: return bp_sync1;
			8'h03: return lvl[k];
			8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09: return slot_sync[c - 8'h04];
			default: return 1'b0;
		endcase
	endfunction : sync_exp

	task automatic check_all(input int i);
		logic [5:0] es, eo;
		logic [1:0] ea;
		for (int b = 0; b < 2; b++) begin
			ea[b] = rows[(i + b) % 12].aoe;
			chk({angle_bus_oe[b], angle_bus[b]}, {ea[b], angle_exp(rows[(i + b) % 12].code)});
		end
		for (int k = 0; k < 6; k++) begin
			eo[k] = rows[(i + k) % 12].soe;
			es[k] = sync_exp(rows[(i + k) % 12].code, k);
			chk({sync_bus_oe[k], sync_bus[k]}, {eo[k], es[k]});
		end
		rdchk(`ACSR_ADDR_STATUS, {18'h0, es, eo, ea});
	endtask : check_all

	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		#100000;
		num_errors++;
		conclude();
	end

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		chk({angle_bus_oe, sync_bus_oe, sync_bus, angle_bus}, 32'h0);
		rdchk(`ACSR_ADDR_SYNC_SEL0, 32'h0);
		rdchk(12'h018, 32'h0);
		wr(`ACSR_ADDR_STATUS, 32'hFFFFFFFF);
		rdchk(`ACSR_ADDR_STATUS, 32'h0);
		wr(`ACSR_ADDR_LEVEL, {26'h0, lvl});
		// each sync line gets a different code, each angle bus shares its same-numbered sync line's code; sources flip under a fixed level
		for (int i = 0; i < 12; i++) begin
			wr(`ACSR_ADDR_ANGLE_SEL0, {24'h0, rows[i].code});
			wr(`ACSR_ADDR_ANGLE_SEL1, {24'h0, rows[(i + 1) % 12].code});
			wr(`ACSR_ADDR_SYNC_SEL0, {rows[(i + 3) % 12].code, rows[(i + 2) % 12].code,
				rows[(i + 1) % 12].code, rows[i].code});
			wr(`ACSR_ADDR_SYNC_SEL1, {16'h0, rows[(i + 5) % 12].code, rows[(i + 4) % 12].code});
			for (int f = 0; f < 2; f++) begin
				flip <= f[0];
				repeat (8) @(posedge hclk);
				check_all(i);
			end
		end
		flip <= 1'b0;
		run <= 1'b1;
		wr(`ACSR_ADDR_ANGLE_SEL0, 32'h1);
		wr(`ACSR_ADDR_ANGLE_SEL1, 32'h4);
		repeat (8) @(posedge hclk);
		n = 0;
		repeat (80) begin
			p = angle_bus[0].angle_clock;
			@(negedge hclk);
			n += int'(angle_bus[0].angle_clock !== p);
		end
		chk(32'(n >= 18 && n <= 22), 32'h1);
		@(posedge hclk);
		wr(`ACSR_ADDR_ANGLE_SEL0, 32'h2);
		repeat (8) @(posedge hclk);
		chk({angle_bus_oe, angle_bus}, {2'h3, slot_angle[0], bp_angle1});
		hresetn <= 1'b0;
		@(negedge hclk);
		chk({angle_bus_oe, sync_bus_oe}, 32'h0);
		@(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
		chk({angle_bus_oe, sync_bus_oe, sync_bus, angle_bus}, 32'h0);
		conclude();
	end
endmodule : angle_clock_and_sync_line_router_test
